// ==== imrs_pkg.sv ====
package imrs_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PRIO = 8'h04;
  localparam logic [7:0] ADDR_LOSSDIV = 8'h08;
  localparam logic [7:0] ADDR_REVAL = 8'h0c;
  localparam logic [7:0] ADDR_HOLDOFF = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_LOSS = 8'h18;

  // ==========================================================
  // register field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SEL_LSB = 2;
  localparam int CTRL_REVERTIVE_ENABLE_BIT = 4;
  localparam int CTRL_PD_BIT = 5;
  localparam int CTRL_BLOCK_BIT = 6;
  localparam int CTRL_DIFF_LSB = 8;
  localparam int HOLDOFF_PRESC_LSB = 8;
  localparam int STATUS_SEL_LSB = 4;
  localparam int STATUS_REFOK_BIT = 6;
  localparam int STATUS_HOLD_BIT = 7;
  localparam int STATUS_MONOK_BIT = 8;
  localparam int LOSS_REF_BIT = 4;

  // ==========================================================
  // reset values
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [1:0] RST_SEL = 2'h0;
  localparam logic RST_REVERTIVE_ENABLE = 1'b0;
  localparam logic RST_PD = 1'b1;
  localparam logic RST_BLOCK = 1'b0;
  localparam logic [7:0] RST_PRIO = 8'he4;
  localparam logic [15:0] RST_LOSSDIV = 16'h000c;
  localparam logic [7:0] RST_REVAL = 8'h04;
  localparam logic [7:0] RST_HOLDOFF_START = 8'h10;
  localparam logic [15:0] RST_HOLDOFF_PRESC = 16'h0100;

  // ==========================================================
  // monitor limits
  localparam logic [1:0] MISS_LIMIT = 2'h3;

  typedef enum logic [1:0]
  {
    MODE_MANUAL = 2'b00,
    MODE_AUTO = 2'b01,
    MODE_SHORT_HOLD = 2'b10,
    MODE_AUTO_HOLD = 2'b11
  } imrs_mode_t;

  typedef enum logic [1:0]
  {
    ST_TRACK = 2'b00,
    ST_HOLDOFF = 2'b01,
    ST_HOLD = 2'b10
  } imrs_state_t;

endpackage

// ==== imrs_input_mon.sv ====
`timescale 1ns/1ps
module imrs_input_mon
  import imrs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic ref_tick,
  input wire logic clk_in,
  input wire logic diff_zero,
  input wire logic [7:0] revalidation_count,
  output logic valid,
  output logic loss_pulse
);
  logic clk_in_d;
  logic seen;
  logic [1:0] miss;
  logic [7:0] good;
  logic edge_now;
  logic [7:0] good_target;

  assign edge_now = clk_in & ~clk_in_d;
  // a zero count would never re-validate; treat it as one period
  assign good_target = (revalidation_count == 8'h00) ? 8'h01 : revalidation_count;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      clk_in_d <= 1'b0;
    else
      clk_in_d <= clk_in;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      seen <= 1'b0;
    else if (ref_tick)
      seen <= 1'b0;
    else if (edge_now)
      seen <= 1'b1;
  end

  // static input never produces edges, so it runs out of ticks
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      miss <= 2'h0;
      good <= 8'h00;
      valid <= 1'b0;
      loss_pulse <= 1'b0;
    end
    else
    begin
      loss_pulse <= 1'b0;
      if (enable && diff_zero)
      begin
        miss <= 2'h0;
        good <= 8'h00;
        valid <= 1'b0;
        loss_pulse <= valid;
      end
      else if (enable && ref_tick)
      begin
        if (seen || edge_now)
        begin
          miss <= 2'h0;
          if (!valid)
          begin
            if (good + 8'h01 >= good_target)
            begin
              good <= 8'h00;
              valid <= 1'b1;
            end
            else
              good <= good + 8'h01;
          end
        end
        else
        begin
          good <= 8'h00;
          if (valid && miss + 2'h1 == MISS_LIMIT)
          begin
            valid <= 1'b0;
            loss_pulse <= 1'b1;
            miss <= 2'h0;
          end
          else if (valid)
            miss <= miss + 2'h1;
        end
      end
    end
  end

endmodule // imrs_input_mon

// ==== imrs_selector.sv ====
`timescale 1ns/1ps
module imrs_selector
  import imrs_pkg::*;
#(
  parameter int NUM_IN = 4,
  parameter int WORD_W = 16
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_IN-1:0] clk_in,
  input wire logic [NUM_IN-1:0] diff_zero,
  input wire logic [WORD_W-1:0] tuning_word,
  output logic [1:0] ref_select,
  output logic ref_ok,
  output logic holdover,
  output logic [WORD_W-1:0] vcxo_word
);
  import imrs_pkg::*;

  // ==========================================================
  // registers
  imrs_mode_t mode;
  logic [1:0] manual_sel;
  logic revertive_enable;
  logic lossdet_divider_powerdown;
  logic monitor_flag_block;
  logic [NUM_IN-1:0] diff_enable;
  logic [7:0] prio;
  logic [15:0] lossdet_reference_divider;
  logic [7:0] revalidation_count;
  logic [7:0] holdoff_start_value;
  logic [15:0] holdoff_prescaler;
  logic [NUM_IN-1:0] input_loss_latched;
  logic ref_loss_latched;

  logic wr_en;
  logic rd_en;
  logic [NUM_IN-1:0] valid;
  logic [NUM_IN-1:0] loss_pulse;
  logic [15:0] div_cnt;
  logic ref_tick;
  logic [15:0] presc_cnt;
  logic holdoff_tick;
  logic [7:0] holdoff_cnt;
  imrs_state_t state;
  logic [2:0] best;
  logic sel_valid;
  logic ref_loss_event;

  // highest priority wins; scanning down from the top index lets the
  // lowest index overwrite an equal priority
  function automatic logic [2:0] best_input(input logic [3:0] v, input logic [7:0] p);
    logic [2:0] res;
    logic [1:0] bp;
    res = 3'b000;
    bp = 2'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (v[i] && (!res[2] || p[2*i+:2] >= bp))
      begin
        res = {1'b1, 2'(i)};
        bp = p[2*i+:2];
      end
    end
    return res;
  endfunction

  // ==========================================================
  // apb slave, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode <= imrs_mode_t'(RST_MODE);
      manual_sel <= RST_SEL;
      revertive_enable <= RST_REVERTIVE_ENABLE;
      lossdet_divider_powerdown <= RST_PD;
      monitor_flag_block <= RST_BLOCK;
      diff_enable <= '0;
      prio <= RST_PRIO;
      lossdet_reference_divider <= RST_LOSSDIV;
      revalidation_count <= RST_REVAL;
      holdoff_start_value <= RST_HOLDOFF_START;
      holdoff_prescaler <= RST_HOLDOFF_PRESC;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        ADDR_CTRL:
        begin
          mode <= imrs_mode_t'(pwdata[CTRL_MODE_LSB+:2]);
          manual_sel <= pwdata[CTRL_SEL_LSB+:2];
          revertive_enable <= pwdata[CTRL_REVERTIVE_ENABLE_BIT];
          lossdet_divider_powerdown <= pwdata[CTRL_PD_BIT];
          monitor_flag_block <= pwdata[CTRL_BLOCK_BIT];
          diff_enable <= pwdata[CTRL_DIFF_LSB+:NUM_IN];
        end
        ADDR_PRIO: prio <= pwdata[7:0];
        ADDR_LOSSDIV: lossdet_reference_divider <= pwdata[15:0];
        ADDR_REVAL: revalidation_count <= pwdata[7:0];
        ADDR_HOLDOFF:
        begin
          holdoff_start_value <= pwdata[7:0];
          holdoff_prescaler <= pwdata[HOLDOFF_PRESC_LSB+:16];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        ADDR_CTRL: prdata <= {20'h00000, 4'(diff_enable), 1'b0, monitor_flag_block,
          lossdet_divider_powerdown, revertive_enable, manual_sel, mode};
        ADDR_PRIO: prdata <= {24'h000000, prio};
        ADDR_LOSSDIV: prdata <= {16'h0000, lossdet_reference_divider};
        ADDR_REVAL: prdata <= {24'h000000, revalidation_count};
        ADDR_HOLDOFF: prdata <= {8'h00, holdoff_prescaler, holdoff_start_value};
        ADDR_STATUS: prdata <= {23'h000000, ~lossdet_divider_powerdown, holdover, ref_ok,
          ref_select, 4'(valid)};
        ADDR_LOSS: prdata <= {27'h0000000, ref_loss_latched, 4'(input_loss_latched)};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_comb
  begin
    pslverr = 1'b0;
    if ((rd_en || wr_en) && paddr > ADDR_LOSS)
      pslverr = 1'b1;
    if ((rd_en || wr_en) && paddr[1:0] != 2'b00)
      pslverr = 1'b1;
  end

  // ==========================================================
  // loss-detect reference divider
  // mismatch against the input rate gives late or false losses
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt <= 16'h0000;
    else if (lossdet_divider_powerdown || ref_tick)
      div_cnt <= 16'h0000;
    else
      div_cnt <= div_cnt + 16'h0001;
  end

  assign ref_tick = !lossdet_divider_powerdown && (div_cnt + 16'h0001 >= lossdet_reference_divider);

  // ==========================================================
  // per-input monitors
  genvar g;
  generate
    for (g = 0; g < NUM_IN; g++)
    begin : gen_mon
      imrs_input_mon u_mon
      (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .enable(~lossdet_divider_powerdown),
        .ref_tick(ref_tick),
        .clk_in(clk_in[g]),
        .diff_zero(diff_zero[g] & diff_enable[g]),
        .revalidation_count(revalidation_count),
        .valid(valid[g]),
        .loss_pulse(loss_pulse[g])
      );
    end
  endgenerate

  // ==========================================================
  // loss flags, set wins over a same-cycle clear
  assign sel_valid = valid[ref_select];
  assign ref_loss_event = loss_pulse[ref_select];

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      input_loss_latched <= '0;
    else
    begin
      for (int i = 0; i < NUM_IN; i++)
      begin
        // a bit already latched just stays set, so no second event is seen
        if (loss_pulse[i] && !monitor_flag_block)
          input_loss_latched[i] <= 1'b1;
        else if (wr_en && paddr == ADDR_LOSS && pwdata[i])
          input_loss_latched[i] <= 1'b0;
      end
    end
  end

  // in ST_HOLD, reached when the hold-off count runs out with no valid input, the reference flag cannot be cleared
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ref_loss_latched <= 1'b0;
    else if (ref_loss_event && !monitor_flag_block)
      ref_loss_latched <= 1'b1;
    else if (wr_en && paddr == ADDR_LOSS && pwdata[LOSS_REF_BIT] && !(state == ST_HOLD))
      ref_loss_latched <= 1'b0;
  end

  // ==========================================================
  // hold-off prescaler and counter, only run while counting down
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      presc_cnt <= 16'h0000;
    else if (state != ST_HOLDOFF || holdoff_tick)
      presc_cnt <= 16'h0000;
    else
      presc_cnt <= presc_cnt + 16'h0001;
  end

  assign holdoff_tick = (state == ST_HOLDOFF) && (presc_cnt + 16'h0001 >= holdoff_prescaler);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      holdoff_cnt <= RST_HOLDOFF_START;
    else if (state != ST_HOLDOFF)
      holdoff_cnt <= holdoff_start_value;
    else if (holdoff_tick)
      holdoff_cnt <= (holdoff_cnt == 8'h00) ? holdoff_start_value : holdoff_cnt - 8'h01;
  end

  // ==========================================================
  // selection state machine
  always_comb best = best_input(4'(valid), prio);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_TRACK;
      ref_select <= RST_SEL;
    end
    else
    begin
      unique case (mode)
        MODE_MANUAL, MODE_SHORT_HOLD:
        begin
          state <= ST_TRACK;
          ref_select <= manual_sel;
        end
        MODE_AUTO:
        begin
          state <= ST_TRACK;
          if (!sel_valid && best[2])
            ref_select <= best[1:0];
          else if (revertive_enable && best[2] && prio[2*best[1:0]+:2] > prio[2*ref_select+:2])
            ref_select <= best[1:0];
        end
        MODE_AUTO_HOLD:
        begin
          unique case (state)
            ST_TRACK:
            begin
              if (!sel_valid)
                state <= ST_HOLDOFF;
              else if (revertive_enable && best[2] &&
                prio[2*best[1:0]+:2] > prio[2*ref_select+:2])
                ref_select <= best[1:0];
            end
            ST_HOLDOFF:
            begin
              // revertive has no effect until the count runs out
              if (holdoff_tick && holdoff_cnt == 8'h00)
              begin
                if (sel_valid)
                  state <= ST_TRACK;
                else if (best[2])
                begin
                  ref_select <= best[1:0];
                  state <= ST_TRACK;
                end
                else
                  state <= ST_HOLD;
              end
            end
            ST_HOLD:
            begin
              if (sel_valid)
                state <= ST_TRACK;
              else if (best[2])
              begin
                ref_select <= best[1:0];
                state <= ST_TRACK;
              end
            end
            default: state <= ST_TRACK;
          endcase
        end
      endcase
    end
  end

  always_comb
  begin
    holdover = 1'b0;
    if (mode == MODE_SHORT_HOLD)
      holdover = ~sel_valid;
    else if (mode == MODE_AUTO_HOLD)
      holdover = (state != ST_TRACK) || !sel_valid;
  end

  assign ref_ok = sel_valid && !holdover;

  // ==========================================================
  // holdover tuning value: frozen copy of the last tracked word
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      vcxo_word <= '0;
    else if (!holdover)
      vcxo_word <= tuning_word;
  end

endmodule // imrs_selector

// ==== imrs_ref_src.sv ====
`timescale 1ns/1ps
module imrs_ref_src
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] run,
  output logic [3:0] clk_in
);
  // ====
  // sources
  // a stopped source parks at its last level, as a dead oscillator would
  logic div;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div <= 1'b0;
      clk_in <= 4'h0;
    end
    else
    begin
      div <= !div;
      if (div)
        clk_in <= clk_in ^ run;
    end
  end
endmodule // imrs_ref_src

// ==== imrs_selector_asserts.sv ====
`timescale 1ns/1ps
module imrs_selector_chk
  import imrs_pkg::*;
#(
  parameter int NUM_IN = 4,
  parameter int WORD_W = 16
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_IN-1:0] clk_in,
  input wire logic [NUM_IN-1:0] diff_zero,
  input wire logic [WORD_W-1:0] tuning_word,
  input wire logic [1:0] ref_select,
  input wire logic ref_ok,
  input wire logic holdover,
  input wire logic [WORD_W-1:0] vcxo_word
);
  // ====
  // snooped mode and select
  logic [3:0] ctrl_q;
  logic wr_ctrl;
  assign wr_ctrl = psel && penable && pwrite && paddr == ADDR_CTRL;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= {RST_SEL, RST_MODE};
    else if (wr_ctrl)
      ctrl_q <= pwdata[3:0];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ====
  // properties
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_err_decode: assert property (psel && penable |->
    pslverr == (paddr > ADDR_LOSS || paddr[1:0] != 2'h0))
    else $error("pslverr decode wrong");
  a_err_rdata: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read data not zero");
  a_hold_freeze: assert property (holdover [*2] |=> $stable(vcxo_word))
    else $error("word moved in holdover");
  a_track_word: assert property (!holdover |=> vcxo_word == $past(tuning_word))
    else $error("word not tracking");
  a_ok_hold: assert property (holdover |-> !ref_ok)
    else $error("ref_ok in holdover");
  a_manual_sel: assert property ((!ctrl_q[0] && !wr_ctrl) [*3] |-> ref_select == ctrl_q[3:2])
    else $error("manual selection not kept");
  a_no_hold: assert property ((!ctrl_q[1] && !wr_ctrl) [*3] |-> !holdover)
    else $error("holdover outside holdover modes");
  c_hold: cover property ($rose(holdover));
  c_switch: cover property (!$stable(ref_select));
  c_refused: cover property (pslverr);
endmodule // imrs_selector_chk

bind imrs_selector imrs_selector_chk #(.NUM_IN(NUM_IN), .WORD_W(WORD_W)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .clk_in(clk_in), .diff_zero(diff_zero), .tuning_word(tuning_word),
  .ref_select(ref_select), .ref_ok(ref_ok), .holdover(holdover), .vcxo_word(vcxo_word));

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import imrs_pkg::*;
  localparam int LDIV = 4;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, holdover, ref_ok;
  logic [3:0] run = 4'h0;
  logic [3:0] diff_zero = 4'h0;
  logic [3:0] clk_in;
  logic [15:0] tuning_word = 16'h0;
  logic [15:0] vcxo_word, w0;
  logic [1:0] ref_select;
  int n_mismatch = 0;
  int tests_run = 0;
  always #50 clk_sys = ~clk_sys;
  // a moving loop value makes a frozen holdover word visible
  always @(posedge clk_sys) tuning_word <= tuning_word + 16'h1;
  imrs_ref_src src (.clk_sys(clk_sys), .rst_n(rst_n), .run(run), .clk_in(clk_in));
  imrs_selector dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_in(clk_in), .diff_zero(diff_zero), .tuning_word(tuning_word),
    .ref_select(ref_select), .ref_ok(ref_ok), .holdover(holdover), .vcxo_word(vcxo_word));
  // ====
  // helpers
  task automatic results();
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic settle();
    run <= 4'hf;
    cyc(10 * LDIV);
    apb(1'b1, ADDR_LOSS, 32'h1f);
  endtask
  // ====
  // scenarios
  task automatic t_reset();
    rdchk(ADDR_CTRL, {25'h0, RST_BLOCK, RST_PD, RST_REVERTIVE_ENABLE, RST_SEL, RST_MODE});
    rdchk(ADDR_PRIO, {24'h0, RST_PRIO});
    rdchk(ADDR_LOSSDIV, {16'h0, RST_LOSSDIV});
    rdchk(ADDR_REVAL, {24'h0, RST_REVAL});
    rdchk(ADDR_HOLDOFF, {8'h0, RST_HOLDOFF_PRESC, RST_HOLDOFF_START});
    rdchk(ADDR_STATUS, 32'h0);
    rdchk(8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask
  task automatic t_monitor();
    apb(1'b1, ADDR_LOSSDIV, LDIV);
    apb(1'b1, ADDR_HOLDOFF, 32'h0102);
    apb(1'b1, ADDR_CTRL, 32'h08);
    run <= 4'hf;
    cyc(10 * LDIV);
    rdchk(ADDR_STATUS, 32'h16f);
    run <= 4'hb;
    cyc(LDIV);
    rdchk(ADDR_STATUS, 32'h16f);
    cyc(5 * LDIV);
    rdchk(ADDR_STATUS, 32'h12b);
    apb(1'b0, ADDR_LOSS, 32'h0);
    chk(rd & 32'hf, 32'h4);
    run <= 4'hf;
    cyc(10 * LDIV);
    rdchk(ADDR_STATUS, 32'h16f);
    apb(1'b1, ADDR_LOSS, 32'h1f);
    rdchk(ADDR_LOSS, 32'h0);
  endtask
  task automatic t_auto();
    apb(1'b1, ADDR_CTRL, 32'h0c);
    apb(1'b1, ADDR_CTRL, 32'h0d);
    run <= 4'h6;
    cyc(6 * LDIV);
    rdchk(ADDR_STATUS, 32'h166);
    apb(1'b0, ADDR_LOSS, 32'h0);
    chk(rd & 32'hf, 32'h9);
    settle();
    rdchk(ADDR_STATUS, 32'h16f);
    apb(1'b1, ADDR_PRIO, 32'hff);
    run <= 4'hb;
    cyc(6 * LDIV);
    rdchk(ADDR_STATUS, 32'h14b);
  endtask
  task automatic t_autohold();
    int n;
    n = 0;
    settle();
    apb(1'b1, ADDR_CTRL, 32'h03);
    run <= 4'he;
    while (holdover !== 1'b1 && n < 8 * LDIV)
    begin
      @(posedge clk_sys);
      n++;
    end
    w0 = vcxo_word;
    @(posedge clk_sys);
    chk({holdover, ref_select, vcxo_word}, {1'b1, 2'h0, w0});
    cyc(8);
    chk({holdover, ref_select}, {1'b0, 2'h1});
  endtask
  task automatic t_block();
    settle();
    apb(1'b1, ADDR_CTRL, 32'h100);
    diff_zero <= 4'h1;
    cyc(3);
    rdchk(ADDR_STATUS, 32'h10e);
    apb(1'b0, ADDR_LOSS, 32'h0);
    chk(rd & 32'hf, 32'h1);
    diff_zero <= 4'h0;
    settle();
    apb(1'b1, ADDR_CTRL, 32'h40);
    run <= 4'hd;
    cyc(6 * LDIV);
    rdchk(ADDR_LOSS, 32'h0);
  endtask
  task automatic t_short();
    settle();
    apb(1'b1, ADDR_CTRL, 32'h06);
    run <= 4'hd;
    cyc(6 * LDIV);
    rdchk(ADDR_STATUS, 32'h19d);
    run <= 4'hf;
    cyc(10 * LDIV);
    rdchk(ADDR_STATUS, 32'h15f);
  endtask
  task automatic t_revert();
    apb(1'b1, ADDR_PRIO, 32'he4);
    apb(1'b1, ADDR_CTRL, 32'h11);
    cyc(2);
    rdchk(ADDR_STATUS, 32'h17f);
    run <= 4'h7;
    cyc(6 * LDIV);
    rdchk(ADDR_STATUS, 32'h167);
    run <= 4'hf;
    cyc(10 * LDIV);
    rdchk(ADDR_STATUS, 32'h17f);
  endtask
  // ====
  // sequence
  initial
  begin
    cyc(8);
    rst_n <= 1'b1;
    t_reset();
    t_monitor();
    t_auto();
    t_autohold();
    t_block();
    t_short();
    t_revert();
    results();
  end
  initial
  begin
    cyc(20000);
    n_mismatch++;
    results();
  end
endmodule // testbench
